// ===== src/ncp_page.sv
// Purpose: Configuration page with four non-volatile registers
// Assumes: Register port is a simple synchronous strobe interface
// Notes:   Scan periods are parameters so simulation can shorten them
`timescale 1ns/1ps
// Function
// RQ1 - Exactly four page registers, each kept in non-volatile storage.
// RQ2 - Config bits 7..4 each connect one trickle-charge resistor when set.
// RQ3 - Config bits 3..2 select the clock output frequency.
// RQ4 - Config bit 1 enables temperature measurement.
// RQ5 - Sample every 1 s when scan bit clear, 16 s when set.
// RQ6 - Offset bit 7 is sign: one fast, zero slow.
// RQ7 - Offset bits 6..0 are magnitude, valid 0 to 121.
// RQ8 - Coefficient register is unsigned 8-bit quadratic drift value.
// RQ9 - Turnover bits 5..0 are temperature in C, valid 4 to 63.
// RQ10 - Host should not overwrite factory calibration registers; the page stores host writes to all four and the bench writes them.
// RQ11 - Temperature register host-writable only while measurement disabled.
// RQ12 - After reset and supply check, copy stored page to working registers.
// RQ13 - Turnover upper two bits read zero, writes ignored.
module ncp_page #(
    parameter longint    FAST_CYC = ncp_pkg::SCAN_FAST_CYC,
    parameter longint    SLOW_CYC = ncp_pkg::SCAN_SLOW_CYC,
    parameter logic [31:0] NV_INIT = 32'h0000_0000
) (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       clk_en,
    input  wire logic       supply_ok,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    output logic            reg_hit,
    input  wire logic [7:0] temp_meas,
    output logic            ready,
    output logic            trickle_res_80_en,
    output logic            trickle_res_20_en,
    output logic            trickle_res_5_en,
    output logic            trickle_res_1p5_en,
    output logic            clock_output_pin_freq_sel_hi,
    output logic            clock_output_pin_freq_sel_lo,
    output logic            therm_en,
    output logic            temp_scan_period,
    output logic            temp_sample,
    output logic            offset_fast,
    output logic      [6:0] offset_mag,
    output logic            offset_valid,
    output logic      [7:0] quad_coef,
    output logic      [5:0] turnover_temp,
    output logic            turnover_valid,
    output logic      [7:0] temp_value
);
    if (FAST_CYC < 2 || SLOW_CYC < FAST_CYC || SLOW_CYC > 64'hFFFF_FFFF) begin
        $error("ncp_page: bad scan counts");
    end

    // ========================================
    // Helpers
    function automatic logic [7:0] clean_word(input logic [1:0] i, input logic [7:0] d);
        clean_word = (i == 2'd3) ? (d & ncp_pkg::MASK_TURNOVER) : d; // RQ13
    endfunction

    typedef enum {ST_WAIT, ST_LOAD, ST_RUN} ncp_state_type;

    ncp_nv_if nv ();
    ncp_nv_store #(.INIT(NV_INIT)) u_store (
        .sys_clk (sys_clk),
        .clk_en  (clk_en),
        .nv      (nv)
    );

    ncp_state_type state_r;
    logic [1:0]    load_idx_r;
    logic [7:0]    work_r [ncp_pkg::NUM_REGS];
    logic [7:0]    temp_r;
    logic [31:0]   scan_cnt_r;
    logic          sample_r;
    logic [7:0]    rdata_r;

    // ========================================
    // Decode
    wire running  = (state_r == ST_RUN);
    wire hit_page = (reg_addr >= ncp_pkg::ADDR_CFG) && (reg_addr <= ncp_pkg::ADDR_TURNOVER);
    wire hit_temp = (reg_addr == ncp_pkg::ADDR_TEMP);
    wire [1:0] page_idx = reg_addr[1:0];
    wire wr_page  = clk_en && running && reg_wr && hit_page; // RQ1
    wire wr_temp  = clk_en && running && reg_wr && hit_temp && !therm_en; // RQ11
    wire [7:0] page_wval = clean_word(page_idx, reg_wdata);
    wire [7:0] rd_mux = hit_page ? work_r[page_idx] : (hit_temp ? temp_r : 8'h00);
    wire [31:0] period_last = temp_scan_period ? 32'(SLOW_CYC - 1)
                                               : 32'(FAST_CYC - 1); // RQ5

    assign nv.idx   = running ? page_idx : load_idx_r;
    assign nv.we    = wr_page;
    assign nv.wdata = page_wval;

    // ========================================
    // Load sequence
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_r    <= ST_WAIT;
            load_idx_r <= 2'd0;
        end else if (clk_en) begin
            case (state_r)
                ST_WAIT: begin
                    if (supply_ok) begin
                        state_r <= ST_LOAD; // RQ12
                    end
                end
                ST_LOAD: begin
                    load_idx_r <= load_idx_r + 2'd1;
                    if (load_idx_r == 2'd3) begin
                        state_r <= ST_RUN;
                    end
                end
                default: state_r <= ST_RUN;
            endcase
        end
    end

    // ========================================
    // Working registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < ncp_pkg::NUM_REGS; i++) begin
                work_r[i] <= ncp_pkg::RST_VAL;
            end
        end else if (clk_en) begin
            if (state_r == ST_LOAD) begin
                work_r[load_idx_r] <= clean_word(load_idx_r, nv.rdata); // RQ12
            end else if (wr_page) begin
                work_r[page_idx] <= page_wval; // RQ1
            end
        end
    end

    // ========================================
    // Temperature register and scan timer
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            temp_r     <= ncp_pkg::RST_VAL;
            scan_cnt_r <= 32'd0;
            sample_r   <= 1'b0;
        end else if (clk_en) begin
            sample_r <= 1'b0;
            if (!running || !therm_en) begin
                scan_cnt_r <= 32'd0;
                if (wr_temp) begin
                    temp_r <= reg_wdata; // RQ11
                end
            end else if (scan_cnt_r >= period_last) begin
                scan_cnt_r <= 32'd0;
                sample_r   <= 1'b1; // RQ5
                temp_r     <= temp_meas; // RQ4
            end else begin
                scan_cnt_r <= scan_cnt_r + 32'd1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata_r <= 8'h00;
        end else if (clk_en && reg_rd) begin
            rdata_r <= rd_mux; // RQ13
        end
    end

    // ========================================
    // Outputs
    assign reg_rdata          = rdata_r;
    assign reg_hit            = hit_page || hit_temp;
    assign ready              = running;
    assign trickle_res_80_en  = work_r[0][ncp_pkg::BIT_RES_80]; // RQ2
    assign trickle_res_20_en  = work_r[0][ncp_pkg::BIT_RES_20]; // RQ2
    assign trickle_res_5_en   = work_r[0][ncp_pkg::BIT_RES_5]; // RQ2
    assign trickle_res_1p5_en = work_r[0][ncp_pkg::BIT_RES_1P5]; // RQ2
    assign clock_output_pin_freq_sel_hi = work_r[0][ncp_pkg::BIT_FSEL_HI]; // RQ3
    assign clock_output_pin_freq_sel_lo = work_r[0][ncp_pkg::BIT_FSEL_LO]; // RQ3
    assign therm_en           = work_r[0][ncp_pkg::BIT_THERM_EN]; // RQ4
    assign temp_scan_period   = work_r[0][ncp_pkg::BIT_SCAN]; // RQ5
    assign temp_sample        = sample_r;
    assign offset_fast        = work_r[1][ncp_pkg::BIT_SIGN]; // RQ6
    assign offset_mag         = work_r[1][6:0]; // RQ7
    assign offset_valid       = (work_r[1][6:0] <= ncp_pkg::OFFSET_MAX); // RQ7
    assign quad_coef          = work_r[2]; // RQ8
    assign turnover_temp      = work_r[3][5:0]; // RQ9
    assign turnover_valid     = (work_r[3][5:0] >= ncp_pkg::TURNOVER_MIN); // RQ9
    assign temp_value         = temp_r;

    // ========================================
    // Checks: page contents and load
    wire [31:0] page_flat = {work_r[3], work_r[2], work_r[1], work_r[0]};

    sequence s_load;
        state_r == ST_WAIT && clk_en && supply_ok ##1 clk_en [*4];
    endsequence

    sequence s_page_wr(logic [1:0] k);
        wr_page && page_idx == k;
    endsequence

    chk_turnover_upper_zero: assert property (@(posedge sys_clk) disable iff (rst) // RQ13
        work_r[3][7:6] == 2'b00)
        else $error("turnover upper bits set");

    chk_load_done: assert property (@(posedge sys_clk) disable iff (rst) // RQ12
        s_load |=> running)
        else $error("page load not finished");

    chk_wait_holds: assert property (@(posedge sys_clk) disable iff (rst) // RQ12
        state_r == ST_WAIT |=> $stable(page_flat))
        else $error("page changed before load");

    chk_load_no_store: assert property (@(posedge sys_clk) disable iff (rst) // RQ12
        !running |-> !nv.we)
        else $error("store written before load done");

    chk_page_write: assert property (@(posedge sys_clk) disable iff (rst) // RQ1
        wr_page |=> work_r[$past(page_idx)] == $past(page_wval))
        else $error("page write lost");

    chk_clk_en_freeze: assert property (@(posedge sys_clk) disable iff (rst) // RQ1
        !clk_en |=> $stable(page_flat) && $stable(state_r) && $stable(load_idx_r) && $stable(temp_r)
            && $stable(scan_cnt_r) && $stable(sample_r) && $stable(rdata_r))
        else $error("state moved while clock enable low");

    chk_rdata_unmapped: assert property (@(posedge sys_clk) disable iff (rst) // RQ1
        clk_en && reg_rd && !reg_hit |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");

    chk_rdata_hold: assert property (@(posedge sys_clk) disable iff (rst) // RQ1
        !(clk_en && reg_rd) |=> $stable(reg_rdata))
        else $error("read data moved without read");

    chk_trickle_map: assert property (@(posedge sys_clk) disable iff (rst) // RQ2
        {trickle_res_80_en, trickle_res_20_en, trickle_res_5_en, trickle_res_1p5_en}
        == work_r[0][7:4])
        else $error("trickle mapping wrong");

    chk_trickle_write: assert property (@(posedge sys_clk) disable iff (rst) // RQ2
        s_page_wr(2'd0) |=> {trickle_res_80_en, trickle_res_20_en, trickle_res_5_en,
            trickle_res_1p5_en} == $past(reg_wdata[7:4]))
        else $error("trickle write lost");

    chk_fsel_write: assert property (@(posedge sys_clk) disable iff (rst) // RQ3
        s_page_wr(2'd0) |=> {clock_output_pin_freq_sel_hi, clock_output_pin_freq_sel_lo} == $past(reg_wdata[3:2]))
        else $error("clock select write lost");

    chk_therm_write: assert property (@(posedge sys_clk) disable iff (rst) // RQ4
        s_page_wr(2'd0) |=> {therm_en, temp_scan_period} == $past(reg_wdata[1:0]))
        else $error("thermometer bits write lost");

    chk_sign_map: assert property (@(posedge sys_clk) disable iff (rst) // RQ6
        wr_page && page_idx == 2'd1 |=> offset_fast == $past(reg_wdata[7]))
        else $error("sign wrong");

    chk_mag_write: assert property (@(posedge sys_clk) disable iff (rst) // RQ7
        s_page_wr(2'd1) |=> offset_mag == $past(reg_wdata[6:0]))
        else $error("offset magnitude write lost");

    chk_coef_write: assert property (@(posedge sys_clk) disable iff (rst) // RQ8
        s_page_wr(2'd2) |=> quad_coef == $past(reg_wdata))
        else $error("coefficient write lost");

    chk_t0_write: assert property (@(posedge sys_clk) disable iff (rst) // RQ9
        s_page_wr(2'd3) |=> turnover_temp == $past(reg_wdata[5:0]))
        else $error("turnover write lost");

    // ========================================
    // Checks: temperature and scan
    chk_temp_wr_locked: assert property (@(posedge sys_clk) disable iff (rst) // RQ11
        (clk_en && therm_en && !sample_r && !$past(sample_r) && running && $stable(therm_en))
        |=> (temp_r == $past(temp_r) || sample_r))
        else $error("temp changed while locked");

    chk_temp_wr_open: assert property (@(posedge sys_clk) disable iff (rst) // RQ11
        wr_temp |=> temp_r == $past(reg_wdata))
        else $error("temp write lost");

    chk_sample_needs_en: assert property (@(posedge sys_clk) disable iff (rst) // RQ4
        sample_r |-> $past(therm_en))
        else $error("sample while disabled");

    chk_sample_in_run: assert property (@(posedge sys_clk) disable iff (rst) // RQ4
        sample_r |-> running)
        else $error("sample before page load");

    chk_sample_value: assert property (@(posedge sys_clk) disable iff (rst) // RQ4
        sample_r |-> temp_value == $past(temp_meas))
        else $error("sample did not capture measurement");

    chk_sample_gap: assert property (@(posedge sys_clk) disable iff (rst) // RQ5
        sample_r && clk_en && therm_en |=> !sample_r)
        else $error("back to back samples");

    chk_scan_idle: assert property (@(posedge sys_clk) disable iff (rst) // RQ5
        clk_en && (!running || !therm_en) |=> scan_cnt_r == 32'd0)
        else $error("scan counter runs while disabled");

    chk_scan_bound: assert property (@(posedge sys_clk) disable iff (rst) // RQ5
        scan_cnt_r < 32'(SLOW_CYC))
        else $error("scan counter past longest period");
endmodule

// ===== src/ncp_pkg.sv
// Purpose: Shared constants for the non-volatile configuration page
// Assumes: 8-bit register bus, addresses as seen on the serial register port
// Notes:   Timing counts derive from the 250 MHz system clock
package ncp_pkg;
    // ========================================
    // Register addresses
    localparam logic [7:0] ADDR_CFG      = 8'h30;
    localparam logic [7:0] ADDR_OFFSET   = 8'h31;
    localparam logic [7:0] ADDR_COEF     = 8'h32;
    localparam logic [7:0] ADDR_TURNOVER = 8'h33;
    localparam logic [7:0] ADDR_TEMP     = 8'h20;
    localparam int         NUM_REGS      = 4;
    // ========================================
    // Field positions
    localparam int BIT_RES_80   = 7;
    localparam int BIT_RES_20   = 6;
    localparam int BIT_RES_5    = 5;
    localparam int BIT_RES_1P5  = 4;
    localparam int BIT_FSEL_HI  = 3;
    localparam int BIT_FSEL_LO  = 2;
    localparam int BIT_THERM_EN = 1;
    localparam int BIT_SCAN     = 0;
    localparam int BIT_SIGN     = 7;
    localparam logic [7:0] MASK_MAG      = 8'h7F;
    localparam logic [7:0] MASK_TURNOVER = 8'h3F;
    localparam logic [6:0] OFFSET_MAX    = 7'h79;
    localparam logic [5:0] TURNOVER_MIN  = 6'h04;
    localparam logic [5:0] TURNOVER_MAX  = 6'h3F;
    // ========================================
    // Reset values of working copies before load
    localparam logic [7:0] RST_VAL = 8'h00;
    // ========================================
    // Timing
    localparam int  CLK_MHZ        = 250;
    localparam int  SCAN_FAST_S    = 1;
    localparam int  SCAN_SLOW_S    = 16;
    localparam longint SCAN_FAST_CYC = longint'(SCAN_FAST_S) * CLK_MHZ * 1000000;
    localparam longint SCAN_SLOW_CYC = longint'(SCAN_SLOW_S) * CLK_MHZ * 1000000;
endpackage

// ===== src/ncp_nv_if.sv
// Purpose: Carrier between the page logic and its non-volatile store
// Assumes: Store answers one word per cycle
// Notes:   Index selects one of the page words
`timescale 1ns/1ps
interface ncp_nv_if;
    logic [1:0] idx;
    logic [7:0] rdata;
    logic       we;
    logic [7:0] wdata;
    modport page  (output idx, output we, output wdata, input rdata);
    modport store (input idx, input we, input wdata, output rdata);
endinterface

// ===== src/ncp_nv_store.sv
// Purpose: Non-volatile array that holds the four page words
// Assumes: Contents persist across rst; only power loss would clear them
// Notes:   Initial contents are the factory defaults passed as a parameter
`timescale 1ns/1ps
module ncp_nv_store #(
    parameter logic [31:0] INIT = 32'h0000_0000
) (
    input  wire logic sys_clk,
    input  wire logic clk_en,
    ncp_nv_if.store   nv
);
    // ========================================
    // Storage, untouched by rst
    logic [7:0] mem_r [ncp_pkg::NUM_REGS] = '{INIT[7:0], INIT[15:8], INIT[23:16], INIT[31:24]};
    always_ff @(posedge sys_clk) begin
        if (clk_en && nv.we) begin
            mem_r[nv.idx] <= nv.wdata; // RQ1
        end
    end
    assign nv.rdata = mem_r[nv.idx];
endmodule

// ===== tb/ncp_host.sv
// Purpose: Host model that drives the page register port
// Assumes: Requests launch on the falling edge and are taken while ready is high
// Notes:   Released address and data lines show the inverse of their last value
`timescale 1ns/1ps
module ncp_host (
    input  wire logic       sys_clk,
    input  wire logic       ready,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata
);
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end
    // One access held until an accepting edge; calibration writes only on request
    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(negedge sys_clk);
        reg_wr    = wr;
        reg_rd    = ~wr;
        reg_addr  = a;
        reg_wdata = d;
        do begin
            @(posedge sys_clk);
            n++;
        end while (ready !== 1'b1 && n < 64);
        @(negedge sys_clk);
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask
endmodule

// ===== tb/test_nonvolatile_config_page_regs.sv
// Purpose: Self-checking bench for the configuration page
// Assumes: Scan periods shortened to 8 and 32 cycles
// Notes:   Expected read values are queued and compared by a monitor
`timescale 1ns/1ps
`define CHK(n, e, g) chk(n, 8'(e), 8'(g))
module test_nonvolatile_config_page_regs;
    localparam logic [31:0] NV = 32'hC4A0_85F2;
    logic       sys_clk = 1'b0, rst = 1'b1, supply_ok = 1'b0, rd_pend = 1'b0;
    logic       clk_en = 1'b1, hit_pend = 1'b0;
    logic [7:0] addr_pend = 8'h00;
    logic       reg_wr, reg_rd, reg_hit, ready, temp_sample, therm_en, temp_scan_period;
    logic       trickle_res_80_en, trickle_res_20_en, trickle_res_5_en, trickle_res_1p5_en;
    logic       clock_output_pin_freq_sel_hi, clock_output_pin_freq_sel_lo, offset_fast, offset_valid;
    logic       turnover_valid;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, quad_coef, temp_value;
    logic [7:0] temp_meas = 8'h00;
    logic [6:0] offset_mag;
    logic [5:0] turnover_temp;
    logic [7:0] m [4];
    logic [7:0] exp_q [$];
    int         fails = 0, total_checks = 0, cyc = 0, p;
    wire  [3:0] trickle_bits = {trickle_res_80_en, trickle_res_20_en,
                                trickle_res_5_en, trickle_res_1p5_en};

    always #2 sys_clk = ~sys_clk;

    ncp_page #(.FAST_CYC(8), .SLOW_CYC(32), .NV_INIT(NV)) ncp_page_i (
        .sys_clk, .rst, .clk_en, .supply_ok, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .reg_rdata, .reg_hit, .temp_meas, .ready, .trickle_res_80_en,
        .trickle_res_20_en, .trickle_res_5_en, .trickle_res_1p5_en, .clock_output_pin_freq_sel_hi,
        .clock_output_pin_freq_sel_lo, .therm_en, .temp_scan_period, .temp_sample, .offset_fast,
        .offset_mag, .offset_valid, .quad_coef, .turnover_temp, .turnover_valid, .temp_value
    );
    ncp_host ncp_host_i (.sys_clk, .ready, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic report_and_stop();
        if (exp_q.size() != 0)
            fails++;
        $display("Checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ========================================
    // Monitor and timeout
    always @(posedge sys_clk) begin
        rd_pend   <= reg_rd & ready;
        hit_pend  <= reg_hit;
        addr_pend <= reg_addr;
    end
    always @(negedge sys_clk) begin
        if (rd_pend) begin
            `CHK("rdata", exp_q.pop_front(), reg_rdata);
            `CHK("hit", addr_pend inside {[8'h30:8'h33], 8'h20}, hit_pend);
        end
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            report_and_stop();
        end
    end
    // ========================================
    // Access helpers
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        ncp_host_i.acc(1'b1, a, d);
        if (a >= 8'h30 && a <= 8'h33)
            m[a[1:0]] = (a == 8'h33) ? (d & 8'h3F) : d;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        ncp_host_i.acc(1'b0, a, 8'h00);
    endtask
    task automatic load();
        int n;
        n = 0;
        `CHK("idle", 0, ready);
        supply_ok = 1'b1;
        while (ready !== 1'b1 && n < 20) begin
            @(negedge sys_clk);
            n++;
        end
        `CHK("load", 1, n >= 4 && n <= 6);
    endtask
    task automatic chk_out();
        `CHK("trickle", m[0][7:4], trickle_bits);
        `CHK("fsel", m[0][3:2], {clock_output_pin_freq_sel_hi, clock_output_pin_freq_sel_lo});
        `CHK("therm", m[0][1:0], {therm_en, temp_scan_period});
        `CHK("sign", m[1][7], offset_fast);
        `CHK("mag", m[1][6:0], offset_mag);
        `CHK("mag_ok", m[1][6:0] <= 7'h79, offset_valid);
        `CHK("coef", m[2], quad_coef);
        `CHK("t0", m[3][5:0], turnover_temp);
        `CHK("t0_ok", m[3][5:0] >= 6'h04, turnover_valid);
        for (int i = 0; i < 4; i++) rd(8'h30 + 8'(i), m[i]);
    endtask
    task automatic gap(output int q);
        q = 0;
        while (temp_sample !== 1'b1 && q < 100) begin
            @(negedge sys_clk);
            q++;
        end
        q = 0;
        do begin
            @(negedge sys_clk);
            q++;
        end while (temp_sample !== 1'b1 && q < 100);
    endtask
    // ========================================
    // Main sequence
    initial begin
        void'($urandom(82899));
        for (int i = 0; i < 4; i++) m[i] = NV[8*i +: 8] & ((i == 3) ? 8'h3F : 8'hFF);
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        repeat (3) @(negedge sys_clk);
        load();
        chk_out();
        for (int r = 0; r < 5; r++) begin
            for (int i = 0; i < 4; i++) wr(8'h30 + 8'(i), 8'($urandom));
            chk_out();
        end
        wr(8'h33, 8'hFF);
        wr(8'h34, 8'hFF);
        rd(8'h34, 8'h00);
        chk_out();
        clk_en = 1'b0;
        ncp_host_i.acc(1'b1, 8'h32, ~m[2]);
        clk_en = 1'b1;
        chk_out();
        wr(8'h30, 8'h00);
        wr(8'h20, 8'h5A);
        rd(8'h20, 8'h5A);
        temp_meas = 8'($urandom);
        wr(8'h30, 8'h02);
        gap(p);
        `CHK("fast", 8, p);
        `CHK("meas", temp_meas, temp_value);
        wr(8'h20, ~temp_meas);
        rd(8'h20, temp_meas);
        wr(8'h30, 8'h03);
        gap(p);
        gap(p);
        `CHK("slow", 32, p);
        rst = 1'b1;
        supply_ok = 1'b0;
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
        @(negedge sys_clk);
        load();
        chk_out();
        repeat (4) @(negedge sys_clk);
        report_and_stop();
    end
endmodule
